// ===== rtl/wd_cfg_pkg.sv
// package: watchdog configuration word layout, register map and timing constants
package wd_cfg_pkg;
    // configuration word field positions
    localparam int WINSZ_LSB = 24;
    localparam int HWEN_BIT = 23;
    localparam int WINOFF_BIT = 22;
    localparam int PS_LSB = 16;
    localparam logic [4:0] PS_MAX = 5'h14;
    // reserved positions read back as ones
    localparam logic [31:0] RSVD_MASK = 32'hfc20_0000;
    localparam logic [31:0] CFG_RESET = 32'hffff_ffff;
    // register byte offsets
    localparam logic [7:0] CFG_OFF = 8'h00;
    localparam logic [7:0] CTRL_OFF = 8'h04;
    localparam logic [7:0] STAT_OFF = 8'h08;
    localparam logic [7:0] IRQ_OFF = 8'h0c;
    localparam logic [7:0] MASK_OFF = 8'h10;
    localparam logic [7:0] CNT_OFF = 8'h14;
    // control register bits
    localparam int CTRL_ON = 0;
    localparam int CTRL_CLR = 1;
    localparam int CTRL_LOAD = 2;
    // interrupt status bits
    localparam int EV_TIMEOUT = 0;
    localparam int EV_EARLY = 1;
    localparam int EV_W = 2;
    // base tick: 1 ms of watchdog base clock
    localparam int TICK_US = 1000;
    localparam int CLK_MHZ = 200;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam logic [4:0] WSZ_25 = 5'h02;
    typedef enum logic [1:0] {win_off_type_dummy} unused_type;
endpackage

// ===== rtl/wd_cfg_if.sv
// interface: decoded watchdog settings passed from decoder to counter
`timescale 1ns/10ps
interface wd_cfg_if;
    logic hw_enable;
    logic window_on;
    logic [1:0] window_size;
    logic [4:0] ps_eff;
    modport src (output hw_enable, output window_on, output window_size, output ps_eff);
    modport dst (input hw_enable, input window_on, input window_size, input ps_eff);
endinterface

// ===== rtl/wd_cfg_decode.sv
// module: decodes the watchdog fields of the configuration word
`timescale 1ns/10ps
module wd_cfg_decode (
    input wire logic [31:0] cfg_word,
    wd_cfg_if.src cfg
);
    // field extraction; out-of-range postscale clamps to the largest ratio
    always_comb begin
        cfg.window_size = cfg_word[wd_cfg_pkg::WINSZ_LSB +: 2]; // R1
        cfg.hw_enable = cfg_word[wd_cfg_pkg::HWEN_BIT]; // R2
        cfg.window_on = ~cfg_word[wd_cfg_pkg::WINOFF_BIT]; // R4
        if (cfg_word[wd_cfg_pkg::PS_LSB +: 5] > wd_cfg_pkg::PS_MAX) begin
            cfg.ps_eff = wd_cfg_pkg::PS_MAX; // R6
        end else begin
            cfg.ps_eff = cfg_word[wd_cfg_pkg::PS_LSB +: 5]; // R5
        end
    end
endmodule

// ===== rtl/watchdog_config_word_decode.sv
// module: watchdog timer configured from the device configuration word, apb register access
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// How it works
// R1 - window size code 11/10/01/00 opens 25/37.5/50/75 percent of timeout
// R2 - hardware enable set: watchdog runs from reset, software off ignored
// R3 - hardware enable clear: idle after reset, software may switch on
// R4 - window-off bit one gives plain mode, zero gives window mode
// R5 - postscale code n divides by two to the n, up to code 10100
// R6 - postscale codes above 10100 act as 10100
// R7 - programmer writes ones to bits 31-26 and bit 21
// R8 - window mode: early clear resets, clear in open window restarts count
module watchdog_config_word_decode (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic wd_reset,
    output logic irq
);
    // software-visible state
    logic [31:0] cfg_q, cfg_d;
    logic sw_on_q, sw_on_d;
    logic [2:0] stat_q, stat_d;
    logic [2:0] mask_q, mask_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic irq_q, irq_d;
    // counter state, with the bus ready and boot flags
    logic [31:0] tick_q, tick_d;
    logic [20:0] cnt_q, cnt_d;
    logic wd_reset_q, wd_reset_d;
    logic pready_q, pready_d;
    logic boot_q, boot_d;

    logic wr, clr_req, load_req, running, mapped;
    logic [20:0] period, open_start;
    logic ev_timeout, ev_early;

    wd_cfg_if cfg_bus ();

    wd_cfg_decode u_decode (
        .cfg_word(cfg_q),
        .cfg(cfg_bus.src)
    );

    assign wr = psel & penable & pwrite & pready_q;
    assign clr_req = wr && paddr == wd_cfg_pkg::CTRL_OFF && pwdata[wd_cfg_pkg::CTRL_CLR];
    assign load_req = wr && paddr == wd_cfg_pkg::CTRL_OFF && pwdata[wd_cfg_pkg::CTRL_LOAD];
    // hardware enable overrides the software switch
    assign running = cfg_bus.hw_enable | sw_on_q; // R2 R3

    // address decode for the error flag; an unaligned or unlisted offset
    // is refused for reads and writes alike, so a stray pointer shows at once
    always_comb begin
        if (paddr == wd_cfg_pkg::CFG_OFF) begin
            mapped = 1'b1;
        end else if (paddr == wd_cfg_pkg::CTRL_OFF) begin
            mapped = 1'b1;
        end else if (paddr == wd_cfg_pkg::STAT_OFF) begin
            mapped = 1'b1;
        end else if (paddr == wd_cfg_pkg::IRQ_OFF) begin
            mapped = 1'b1;
        end else if (paddr == wd_cfg_pkg::MASK_OFF) begin
            mapped = 1'b1;
        end else if (paddr == wd_cfg_pkg::CNT_OFF) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // timeout period in postscaled ticks and the start of the open window
    // limitation: a one-tick period cannot resolve a window; every window code is exact only from postscale code 3 up
    always_comb begin
        period = 21'h000001 << cfg_bus.ps_eff; // R5
        case (cfg_bus.window_size) // R1
            2'b11: open_start = period - (period >> 2);
            2'b10: open_start = period - (period >> 2) - (period >> 3);
            2'b01: open_start = period >> 1;
            default: open_start = period >> 2;
        endcase
    end

    // apb decode and register updates; hardware event set beats clear
    always_comb begin
        cfg_d = cfg_q;
        sw_on_d = sw_on_q;
        mask_d = mask_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        boot_d = 1'b0;
        // every setup is answered at the next edge: no wait states
        pready_d = psel & ~penable;
        stat_d = stat_q;
        // configuration word is latched once after reset from the stored image
        if (boot_q) begin
            cfg_d = wd_cfg_pkg::CFG_RESET;
        end
        if (wr) begin
            if (paddr == wd_cfg_pkg::CFG_OFF) begin
                // stands in for reprogramming; reserved bits forced to one
                cfg_d = pwdata | wd_cfg_pkg::RSVD_MASK; // R7
            end else if (paddr == wd_cfg_pkg::CTRL_OFF) begin
                sw_on_d = pwdata[wd_cfg_pkg::CTRL_ON]; // R3
            end else if (paddr == wd_cfg_pkg::IRQ_OFF) begin
                stat_d = stat_q & ~pwdata[2:0];
            end else if (paddr == wd_cfg_pkg::MASK_OFF) begin
                mask_d = pwdata[2:0];
            end
        end else if (psel & ~penable & ~pwrite) begin
            if (paddr == wd_cfg_pkg::CFG_OFF) begin
                prdata_d = cfg_q;
            end else if (paddr == wd_cfg_pkg::CTRL_OFF) begin
                prdata_d = {31'h0, sw_on_q};
            end else if (paddr == wd_cfg_pkg::STAT_OFF) begin
                prdata_d = {24'h0, cfg_bus.ps_eff, cfg_bus.window_on, running, wd_reset_q};
            end else if (paddr == wd_cfg_pkg::IRQ_OFF) begin
                prdata_d = {29'h0, stat_q};
            end else if (paddr == wd_cfg_pkg::MASK_OFF) begin
                prdata_d = {29'h0, mask_q};
            end else if (paddr == wd_cfg_pkg::CNT_OFF) begin
                prdata_d = {11'h0, cnt_q};
            end else begin
                prdata_d = 32'h0;
            end
        end
        if (psel & ~penable) begin
            pslverr_d = ~mapped; // decided in setup so the flag stands with pready
        end
        if (ev_timeout) begin
            stat_d[wd_cfg_pkg::EV_TIMEOUT] = 1'b1;
        end
        if (ev_early) begin
            stat_d[wd_cfg_pkg::EV_EARLY] = 1'b1;
        end
        if (clr_req && cfg_bus.window_on && cnt_q >= open_start) begin
            stat_d[wd_cfg_pkg::EV_W] = 1'b1;
        end
        irq_d = |(stat_d & mask_d);
    end

    // register stage of the bus and status side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= wd_cfg_pkg::CFG_RESET;
            sw_on_q <= 1'b0;
            mask_q <= 3'h0;
            stat_q <= 3'h0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
            pready_q <= 1'b0;
            irq_q <= 1'b0;
            boot_q <= 1'b1;
        end else begin
            cfg_q <= cfg_d;
            sw_on_q <= sw_on_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            pready_q <= pready_d;
            irq_q <= irq_d;
            boot_q <= boot_d;
        end
    end

    // watchdog counter: base tick then postscaled count
    always_comb begin
        tick_d = tick_q;
        cnt_d = cnt_q;
        ev_timeout = 1'b0;
        ev_early = 1'b0;
        wd_reset_d = 1'b0;
        // reload and switch-off win over a clear; a clear beats a tick end
        if (!running || load_req) begin
            tick_d = 32'h0;
            cnt_d = 21'h0;
        end else if (clr_req) begin
            tick_d = 32'h0;
            cnt_d = 21'h0; // R8
            if (cfg_bus.window_on && cnt_q < open_start) begin
                ev_early = 1'b1; // R8
                wd_reset_d = 1'b1; // R8
            end
        end else if (tick_q == 32'(wd_cfg_pkg::TICK_CYC - 1)) begin
            tick_d = 32'h0;
            if (cnt_q == period - 21'h000001) begin
                cnt_d = 21'h0;
                ev_timeout = 1'b1;
                wd_reset_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 21'h000001;
            end
        end else begin
            tick_d = tick_q + 32'h1;
        end
    end

    // register stage of the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 32'h0;
            cnt_q <= 21'h0;
            wd_reset_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            cnt_q <= cnt_d;
            wd_reset_q <= wd_reset_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign wd_reset = wd_reset_q;
    assign irq = irq_q;
endmodule

// ===== verification/wd_cfg_properties.sv
// checker: bus timing and register read relations of the watchdog block
`timescale 1ns/10ps
module wd_cfg_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wd_reset,
    input wire logic irq
);
    // a setup cycle is the cause of every answer
    wire setup = psel && !penable;
    wire rd_setup = setup && !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (setup |=> pready)
        else $error("ready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_unmapped: assert property (setup && paddr > 8'h14 |=> pslverr)
        else $error("unmapped address not refused");
    a_cfg_no_err: assert property (setup && paddr == 8'h00 |=> pready && !pslverr)
        else $error("config access refused");
    a_rsvd_read_ones: assert property (
        rd_setup && paddr == 8'h00 |=> (prdata & 32'hfc20_0000) == 32'hfc20_0000)
        else $error("reserved bits not read as ones");
    a_ps_clamped: assert property (
        rd_setup && paddr == 8'h08 |=> prdata[7:3] <= 5'h14)
        else $error("postscale above largest code");
    a_reset_one_cycle: assert property (wd_reset |=> !wd_reset)
        else $error("watchdog reset longer than one cycle");
endmodule

// ===== verification/tb.sv
// testbench: register level checks of the watchdog configuration decode
`timescale 1ns/10ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic wd_reset;
    logic irq;
    logic err;
    logic [4:0] codes [5] = '{5'h00, 5'h05, 5'h14, 5'h15, 5'h1f};
    int n_mismatch = 0;
    int checked = 0;
    int pulses = 0;
    watchdog_config_word_decode DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .wd_reset(wd_reset), .irq(irq));
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    // counts watchdog reset pulses, sampled at the edge
    always @(posedge pclk) begin
        if (wd_reset === 1'b1) begin
            pulses <= pulses + 1;
        end
    end
    // one transfer; the wait has no bound of its own, the watchdog below ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // write the word, reload it, read status back
    task automatic setcfg(input logic [31:0] v);
        apb(1'b1, wd_cfg_pkg::CFG_OFF, v | wd_cfg_pkg::RSVD_MASK);
        apb(1'b1, wd_cfg_pkg::CTRL_OFF, 32'h0000_0004);
        apb(1'b0, wd_cfg_pkg::STAT_OFF, 32'h0000_0000);
    endtask
    task automatic print_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // a hang past this span is a failure
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, wd_cfg_pkg::CFG_OFF, 32'h0000_0000);
        chk("cfg reset", rd, wd_cfg_pkg::CFG_RESET);
        apb(1'b0, wd_cfg_pkg::STAT_OFF, 32'h0000_0000);
        chk("status reset", rd & 32'h0000_00fe, 32'h0000_00a2);
        // reload with software off bit clear: hw enable keeps it running
        foreach (codes[i]) begin
            setcfg(wd_cfg_pkg::RSVD_MASK | 32'h00c0_0000 | (32'(codes[i]) << 16));
            chk("postscale", rd & 32'h0000_00fe,
                {24'h0, (codes[i] > 5'h14) ? 5'h14 : codes[i], 3'h2});
        end
        apb(1'b1, wd_cfg_pkg::CFG_OFF, wd_cfg_pkg::RSVD_MASK);
        apb(1'b0, wd_cfg_pkg::CFG_OFF, 32'h0000_0000);
        chk("reserved ones", rd, wd_cfg_pkg::RSVD_MASK);
        // window code 11 on a one-tick period: the window opens only at its end
        setcfg(32'h0300_0000);
        chk("sw idle", rd & 32'h0000_00fe, 32'h0000_0004);
        apb(1'b1, wd_cfg_pkg::CTRL_OFF, 32'h0000_0001);
        apb(1'b0, wd_cfg_pkg::STAT_OFF, 32'h0000_0000);
        chk("sw on", rd & 32'h0000_00fe, 32'h0000_0006);
        // clear at once: the window is still shut
        apb(1'b1, wd_cfg_pkg::CTRL_OFF, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        chk("early pulse", 32'(pulses), 32'h0000_0001);
        apb(1'b0, wd_cfg_pkg::IRQ_OFF, 32'h0000_0000);
        chk("early flag", rd & 32'h0000_0002, 32'h0000_0002);
        chk("irq masked", {31'h0, irq}, 32'h0000_0000);
        apb(1'b1, wd_cfg_pkg::MASK_OFF, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk("irq on", {31'h0, irq}, 32'h0000_0001);
        apb(1'b1, wd_cfg_pkg::IRQ_OFF, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
        // window code 00 on a one-tick period is open at once: clear is in window
        setcfg(32'h0080_0000);
        apb(1'b1, wd_cfg_pkg::CTRL_OFF, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk("window no pulse", 32'(pulses), 32'h0000_0001);
        apb(1'b0, wd_cfg_pkg::IRQ_OFF, 32'h0000_0000);
        chk("window flag", rd & 32'h0000_0004, 32'h0000_0004);
        // plain mode: an early clear is harmless
        setcfg(wd_cfg_pkg::RSVD_MASK | 32'h00c0_0000);
        apb(1'b1, wd_cfg_pkg::CTRL_OFF, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        chk("no pulse", 32'(pulses), 32'h0000_0001);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", {31'h0, err}, 32'h0000_0001);
        print_verdict();
    end
endmodule
bind watchdog_config_word_decode wd_cfg_properties chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wd_reset(wd_reset), .irq(irq));
